// >>> lpit_probe.sv
// Probe pin I/O and three-channel trigger/capture core with Avalon-MM slave
// Operation
// RL1: Direction and output-state writes only take effect while pin I/O is enabled.
// RL2: Clock, data and auxiliary pins each selectable as driven output or input.
// RL3: Programming-voltage pin is output only; input requests are ignored.
// RL4: Input pins are sampled and their current level reported to software.
// RL5: Output pins drive the level held in their stored output-state bit.
// RL6: A toggle request inverts the stored output bit; the pin follows.
// RL7: Analyzer captures up to three input channels at once.
// RL8: Analyzer maps clock, data, auxiliary pins to channels one, two, three.
// RL9: Don't-care channel always counts as satisfied.
// RL10: High code satisfied only when the channel reads high.
// RL11: Low code satisfied only when the channel reads low.
// RL12: Rising code satisfied only on a low-to-high change.
// RL13: Falling code satisfied only on a high-to-low change.
// RL14: Trigger fires only when all channels are satisfied in one sample.
// RL15: Firing starts capture; before that conditions are evaluated without recording.
// RL16: Each capture holds exactly 1024 samples of all channels.
// RL17: With delay set, recording starts after 1000 samples per delay window.
// RL18: Edges compare each sample with the previous one at the sample rate.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module lpit_probe #(
    parameter int capture_len = lpit_pkg::lpit_capture_len,
    parameter int window_samples = lpit_pkg::lpit_window_samples
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Probe pins
    input wire lpit_pkg::lpit_pins_type pin_in,
    output lpit_pkg::lpit_pins_type pin_out,
    output lpit_pkg::lpit_pins_type pin_oe_b,
    output logic programming_voltage_out
);
    localparam int idx_w = $clog2(capture_len);
    localparam int dly_w = 20;

    logic rst_meta, rst_sync_b;
    lpit_pkg::lpit_pins_type pin_meta, pin_sync;
    logic io_en, ana_mode;
    logic [2:0] dir;
    logic [3:0] out_state;
    lpit_pkg::lpit_trig_type trig_cond;
    logic [15:0] rate_div;
    logic [3:0] delay_win;
    logic [15:0] div_cnt;
    logic tick;
    logic [2:0] prev_sample;
    logic fire;
    lpit_pkg::lpit_state_type state;
    logic [dly_w-1:0] delay_cnt;
    logic [idx_w:0] rec_cnt;
    logic [2:0] cap_mem [0:capture_len-1];
    logic [idx_w-1:0] cap_rd_idx;
    logic acc_ok, wr_go, rd_go;
    logic io_active;
    logic [31:0] next_rdata;

    function automatic logic is_reg(input logic [5:0] a, input logic [5:0] off);
        return a == off;
    endfunction : is_reg

    // Reset release
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // Pin synchroniser
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Bus handshake: one wait cycle, then answer
    assign acc_ok = (avs_read || avs_write) && !avs_waitrequest;
    assign wr_go = avs_write && !avs_waitrequest;
    assign rd_go = avs_read && avs_waitrequest;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            avs_waitrequest <= 1'b1;
        end else if (acc_ok) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (is_reg(avs_address, lpit_pkg::lpit_off_ctrl)) begin
            next_rdata = {30'h0, ana_mode, io_en};
        end else if (is_reg(avs_address, lpit_pkg::lpit_off_dir)) begin
            // Voltage pin always reads as output
            next_rdata = {28'h0, 1'b1, dir}; // [RL3]
        end else if (is_reg(avs_address, lpit_pkg::lpit_off_out)) begin
            next_rdata = {28'h0, out_state};
        end else if (is_reg(avs_address, lpit_pkg::lpit_off_in)) begin
            next_rdata = {29'h0, pin_sync}; // [RL4]
        end else if (is_reg(avs_address, lpit_pkg::lpit_off_trig)) begin
            next_rdata = {23'h0, trig_cond};
        end else if (is_reg(avs_address, lpit_pkg::lpit_off_acq)) begin
            next_rdata = {12'h0, delay_win, rate_div};
        end else if (is_reg(avs_address, lpit_pkg::lpit_off_status)) begin
            next_rdata = {5'h0, 11'(rec_cnt), 11'h0, state};
        end else if (is_reg(avs_address, lpit_pkg::lpit_off_capidx)) begin
            next_rdata = {22'h0, 10'(cap_rd_idx)};
        end else if (is_reg(avs_address, lpit_pkg::lpit_off_capdata)) begin
            next_rdata = {29'h0, cap_mem[cap_rd_idx]};
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            avs_readdata <= next_rdata;
        end
    end

    // Mode control
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            io_en <= 1'b0;
            ana_mode <= 1'b0;
        end else if (wr_go && is_reg(avs_address, lpit_pkg::lpit_off_ctrl)) begin
            io_en <= avs_writedata[lpit_pkg::lpit_ctrl_io_en];
            ana_mode <= avs_writedata[lpit_pkg::lpit_ctrl_ana];
        end
    end

    // Direction, only once I/O is enabled
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            dir <= lpit_pkg::lpit_dir_rst;
        end else if (wr_go && io_en && is_reg(avs_address, lpit_pkg::lpit_off_dir)) begin // [RL1]
            dir <= avs_writedata[2:0]; // [RL2] [RL3]
        end
    end

    // Output states: plain write or toggle
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            out_state <= lpit_pkg::lpit_out_rst;
        end else if (wr_go && io_en) begin // [RL1]
            if (is_reg(avs_address, lpit_pkg::lpit_off_out)) begin
                out_state <= avs_writedata[3:0];
            end else if (is_reg(avs_address, lpit_pkg::lpit_off_toggle)) begin
                out_state <= out_state ^ avs_writedata[3:0]; // [RL6]
            end
        end
    end

    // Trigger and acquisition settings
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            trig_cond <= '0;
            rate_div <= lpit_pkg::lpit_div_rst;
            delay_win <= lpit_pkg::lpit_win_rst;
            cap_rd_idx <= '0;
        end else if (wr_go) begin
            if (is_reg(avs_address, lpit_pkg::lpit_off_trig)) begin
                trig_cond <= lpit_pkg::lpit_trig_type'(avs_writedata[8:0]);
            end else if (is_reg(avs_address, lpit_pkg::lpit_off_acq)) begin
                rate_div <= avs_writedata[15:0];
                delay_win <= avs_writedata[lpit_pkg::lpit_acq_win_lsb +: 4];
            end else if (is_reg(avs_address, lpit_pkg::lpit_off_capidx)) begin
                cap_rd_idx <= avs_writedata[idx_w-1:0];
            end
        end
    end

    // Pin drive; analyzer mode forces all three pins to inputs
    assign io_active = io_en && !ana_mode;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_out <= '0;
            pin_oe_b <= '1;
            programming_voltage_out <= 1'b0;
        end else begin
            pin_out <= out_state[2:0]; // [RL5]
            pin_oe_b <= ~(dir & {3{io_active}}); // [RL2] [RL8]
            programming_voltage_out <= io_active && out_state[lpit_pkg::lpit_vpp_bit]; // [RL3]
        end
    end

    // Sample-rate divider
    assign tick = (div_cnt == 16'h0000);

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            div_cnt <= 16'h0000;
        end else if (tick || state == lpit_pkg::lpit_st_idle) begin
            div_cnt <= rate_div;
        end else begin
            div_cnt <= div_cnt - 16'h0001;
        end
    end

    // Previous sample, held at sample rate
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            prev_sample <= 3'h0;
        end else if (tick) begin
            prev_sample <= pin_sync; // [RL18]
        end
    end

    // Channel one = clock, two = data, three = aux
    lpit_trig u_trig (
        .cur(pin_sync), // [RL7] [RL8]
        .prev(prev_sample),
        .cond(trig_cond),
        .fire(fire)
    );

    // Acquisition sequencer
    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= lpit_pkg::lpit_st_idle;
            delay_cnt <= '0;
            rec_cnt <= '0;
        end else if (wr_go && is_reg(avs_address, lpit_pkg::lpit_off_ctrl)
                     && avs_writedata[lpit_pkg::lpit_ctrl_stop]) begin
            state <= lpit_pkg::lpit_st_idle;
        end else begin
            case (state)
                lpit_pkg::lpit_st_idle, lpit_pkg::lpit_st_done: begin
                    if (wr_go && is_reg(avs_address, lpit_pkg::lpit_off_ctrl)
                        && avs_writedata[lpit_pkg::lpit_ctrl_run]
                        && avs_writedata[lpit_pkg::lpit_ctrl_ana]) begin
                        state <= lpit_pkg::lpit_st_arm;
                        rec_cnt <= '0;
                    end
                end
                lpit_pkg::lpit_st_arm: begin
                    // Trigger checked from the first tick on; edges use the previous tick's sample
                    if (tick && fire) begin // [RL14] [RL15]
                        delay_cnt <= dly_w'(window_samples * delay_win); // [RL17]
                        state <= (delay_win == 4'h0) ? lpit_pkg::lpit_st_rec
                                                     : lpit_pkg::lpit_st_delay;
                    end
                end
                lpit_pkg::lpit_st_delay: begin
                    if (tick) begin
                        delay_cnt <= delay_cnt - dly_w'(1);
                        if (delay_cnt == dly_w'(1)) begin
                            state <= lpit_pkg::lpit_st_rec; // [RL17]
                        end
                    end
                end
                lpit_pkg::lpit_st_rec: begin
                    if (tick) begin
                        rec_cnt <= rec_cnt + (idx_w+1)'(1);
                        if (rec_cnt == (idx_w+1)'(capture_len - 1)) begin
                            state <= lpit_pkg::lpit_st_done; // [RL16]
                        end
                    end
                end
                default: begin
                    state <= lpit_pkg::lpit_st_idle;
                end
            endcase
        end
    end

    // Capture storage, written only while recording
    always_ff @(posedge mclk) begin
        if (state == lpit_pkg::lpit_st_rec && tick) begin
            cap_mem[rec_cnt[idx_w-1:0]] <= pin_sync; // [RL15] [RL16]
        end
    end

    property p_dir_gate;
        @(posedge mclk) disable iff (!rst_sync_b)
        (wr_go && !io_en) |=> $stable(dir);
    endproperty
    a_dir_gate: assert property (p_dir_gate) else $error("dir changed while io disabled"); // [RL1]

    property p_pin_dir;
        @(posedge mclk) disable iff (!rst_sync_b)
        ##1 pin_oe_b == ~($past(dir) & {3{$past(io_active)}});
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("pin enable not following dir"); // [RL2]

    property p_vpp_out;
        @(posedge mclk) disable iff (!rst_sync_b)
        (io_active && out_state[3]) |=> programming_voltage_out;
    endproperty
    a_vpp_out: assert property (p_vpp_out) else $error("voltage pin not driven"); // [RL3]

    property p_in_read;
        @(posedge mclk) disable iff (!rst_sync_b)
        (rd_go && avs_address == lpit_pkg::lpit_off_in) |=> avs_readdata[2:0] == $past(pin_sync);
    endproperty
    a_in_read: assert property (p_in_read) else $error("input level misreported"); // [RL4]

    property p_out_level;
        @(posedge mclk) disable iff (!rst_sync_b)
        ##1 pin_out == $past(out_state[2:0]);
    endproperty
    a_out_level: assert property (p_out_level) else $error("pin level not output bit"); // [RL5]

    property p_toggle;
        @(posedge mclk) disable iff (!rst_sync_b)
        (wr_go && io_en && avs_address == lpit_pkg::lpit_off_toggle)
            |=> out_state == ($past(out_state) ^ $past(avs_writedata[3:0]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle did not invert"); // [RL6]

    property p_ana_input;
        @(posedge mclk) disable iff (!rst_sync_b)
        ana_mode [*2] |-> pin_oe_b == 3'h7;
    endproperty
    a_ana_input: assert property (p_ana_input) else $error("pin driven in analyzer mode"); // [RL8]

    property p_no_early_rec;
        @(posedge mclk) disable iff (!rst_sync_b)
        (state == lpit_pkg::lpit_st_arm && !(tick && fire)) |=> state != lpit_pkg::lpit_st_rec;
    endproperty
    a_no_early_rec: assert property (p_no_early_rec) else $error("recording without trigger"); // [RL14]

    property p_rec_len;
        @(posedge mclk) disable iff (!rst_sync_b)
        (state == lpit_pkg::lpit_st_rec) |-> rec_cnt < (idx_w+1)'(capture_len);
    endproperty
    a_rec_len: assert property (p_rec_len) else $error("capture longer than buffer"); // [RL16]

    property p_wait_short;
        @(posedge mclk) disable iff (!rst_sync_b)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_short: assert property (p_wait_short) else $error("waitrequest held too long"); // [RL4]

    c_fire: cover property (@(posedge mclk) disable iff (!rst_sync_b)
        state == lpit_pkg::lpit_st_arm && tick && fire);
    c_delay: cover property (@(posedge mclk) disable iff (!rst_sync_b)
        state == lpit_pkg::lpit_st_delay ##1 state == lpit_pkg::lpit_st_rec);
    c_done: cover property (@(posedge mclk) disable iff (!rst_sync_b)
        state == lpit_pkg::lpit_st_done);
    c_toggle: cover property (@(posedge mclk) disable iff (!rst_sync_b)
        wr_go && io_en && avs_address == lpit_pkg::lpit_off_toggle);
endmodule : lpit_probe

// >>> lpit_trig.sv
// Package for the probe block and the per-channel trigger matcher
package lpit_pkg;
    localparam int lpit_channels = 3;
    localparam int lpit_capture_len = 1024;
    localparam int lpit_window_samples = 1000;
    localparam int lpit_addr_w = 6;
    // Register byte offsets
    localparam logic [5:0] lpit_off_ctrl = 6'h00;
    localparam logic [5:0] lpit_off_dir = 6'h04;
    localparam logic [5:0] lpit_off_out = 6'h08;
    localparam logic [5:0] lpit_off_toggle = 6'h0c;
    localparam logic [5:0] lpit_off_in = 6'h10;
    localparam logic [5:0] lpit_off_trig = 6'h14;
    localparam logic [5:0] lpit_off_acq = 6'h18;
    localparam logic [5:0] lpit_off_status = 6'h1c;
    localparam logic [5:0] lpit_off_capidx = 6'h20;
    localparam logic [5:0] lpit_off_capdata = 6'h24;
    // Control fields
    localparam int lpit_ctrl_io_en = 0;
    localparam int lpit_ctrl_ana = 1;
    localparam int lpit_ctrl_run = 2;
    localparam int lpit_ctrl_stop = 3;
    // Acquisition fields
    localparam int lpit_acq_win_lsb = 16;
    // Output state bit of the programming-voltage pin
    localparam int lpit_vpp_bit = 3;
    // Reset values
    localparam logic [2:0] lpit_dir_rst = 3'h0;
    localparam logic [3:0] lpit_out_rst = 4'h0;
    localparam logic [15:0] lpit_div_rst = 16'h0000;
    localparam logic [3:0] lpit_win_rst = 4'h0;

    typedef enum logic [2:0] {
        lpit_cond_any = 3'h0,
        lpit_cond_high = 3'h1,
        lpit_cond_low = 3'h2,
        lpit_cond_rise = 3'h3,
        lpit_cond_fall = 3'h4
    } lpit_cond_type;

    typedef struct packed {
        lpit_cond_type ch3;
        lpit_cond_type ch2;
        lpit_cond_type ch1;
    } lpit_trig_type;

    typedef struct packed {
        logic aux;
        logic data;
        logic clk;
    } lpit_pins_type;

    typedef enum logic [4:0] {
        lpit_st_idle = 5'b00001,
        lpit_st_arm = 5'b00010,
        lpit_st_delay = 5'b00100,
        lpit_st_rec = 5'b01000,
        lpit_st_done = 5'b10000
    } lpit_state_type;
endpackage : lpit_pkg

`timescale 1ns/100ps
module lpit_trig (
    // Samples
    input wire logic [2:0] cur,
    input wire logic [2:0] prev,
    // Conditions
    input wire lpit_pkg::lpit_trig_type cond,
    // Result
    output logic fire
);
    logic [2:0] hit;
    logic [8:0] cond_bits;

    function automatic logic chan_match(input logic [2:0] code, input logic c, input logic p);
        logic r;
        r = 1'b0;
        if (code == lpit_pkg::lpit_cond_any) begin
            r = 1'b1; // [RL9]
        end else if (code == lpit_pkg::lpit_cond_high) begin
            r = c; // [RL10]
        end else if (code == lpit_pkg::lpit_cond_low) begin
            r = !c; // [RL11]
        end else if (code == lpit_pkg::lpit_cond_rise) begin
            r = c && !p; // [RL12] [RL18]
        end else if (code == lpit_pkg::lpit_cond_fall) begin
            r = !c && p; // [RL13] [RL18]
        end
        return r;
    endfunction : chan_match

    assign cond_bits = cond;

    for (genvar i = 0; i < 3; i++) begin : g_ch
        assign hit[i] = chan_match(cond_bits[3*i +: 3], cur[i], prev[i]);
    end

    // All channels in the same sample
    assign fire = &hit; // [RL14]
endmodule : lpit_trig

// >>> lpit_target_model.sv
// Behavioural model of the target circuit wired to the three probe lines
`timescale 1ns/100ps
module lpit_target_model (
    // Clock
    input wire logic mclk,
    // Block side
    input wire lpit_pkg::lpit_pins_type pin_out,
    input wire lpit_pkg::lpit_pins_type pin_oe_b,
    // Target drivers, bit0 clock line, bit1 data line, bit2 auxiliary line
    input wire logic [2:0] drv_en,
    input wire logic [2:0] drv_val,
    // Resolved wire levels
    output lpit_pkg::lpit_pins_type wire_lvl
);
    logic last_aux = 1'b0;
    logic [2:0] lvl;

    // Clock and data lines carry pull-downs; the auxiliary line floats
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (!pin_oe_b[i]) begin
                lvl[i] = pin_out[i];
            end else if (drv_en[i]) begin
                lvl[i] = drv_val[i];
            end else if (i < 2) begin
                lvl[i] = 1'b0;
            end else begin
                // Floating line: never let a stale level pass for a real one
                lvl[i] = ~last_aux;
            end
        end
    end

    assign wire_lvl = lpit_pkg::lpit_pins_type'(lvl);

    always_ff @(posedge mclk) begin
        if (!pin_oe_b[2] || drv_en[2]) begin
            last_aux <= lvl[2];
        end
    end
endmodule : lpit_target_model

// >>> testbench.sv
// Self-checking bench for the probe pin and trigger block
`timescale 1ns/100ps
module testbench;
    logic mclk;
    logic rst_b;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    lpit_pkg::lpit_pins_type pin_in;
    lpit_pkg::lpit_pins_type pin_out;
    lpit_pkg::lpit_pins_type pin_oe_b;
    logic programming_voltage_out;
    logic [2:0] drv_en;
    logic [2:0] drv_val;
    int bad_count;
    int n_compared;
    int cycles;
    logic [31:0] rd;

    // Short counts keep the capture runs brief
    lpit_probe #(.capture_len(16), .window_samples(4)) dut (
        .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_b(pin_oe_b), .programming_voltage_out(programming_voltage_out));

    lpit_target_model target (.mclk(mclk), .pin_out(pin_out), .pin_oe_b(pin_oe_b),
        .drv_en(drv_en), .drv_val(drv_val), .wire_lvl(pin_in));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One Avalon access; holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b1, 1'b0);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask : bus

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk

    task automatic drive(input logic [2:0] en, input logic [2:0] val, input int wait_n);
        drv_en <= en;
        drv_val <= val;
        repeat (wait_n) @(posedge mclk);
    endtask : drive

    task automatic wait_done;
        int n;
        n = 0;
        do begin
            bus(1'b0, lpit_pkg::lpit_off_status, 32'h0);
            n++;
        end while (rd[4] !== 1'b1 && n < 200);
        chk(rd, 32'h0010_0010);
    endtask : wait_done

    task automatic t_reset_and_refuse;
        rd_chk(lpit_pkg::lpit_off_dir, 32'h8);
        rd_chk(lpit_pkg::lpit_off_out, 32'h0);
        rd_chk(lpit_pkg::lpit_off_status, 32'h1);
        rd_chk(6'h3c, 32'h0);
        bus(1'b1, lpit_pkg::lpit_off_dir, 32'h7);
        bus(1'b1, lpit_pkg::lpit_off_out, 32'hf);
        rd_chk(lpit_pkg::lpit_off_dir, 32'h8);
        rd_chk(lpit_pkg::lpit_off_out, 32'h0);
        chk({29'h0, pin_oe_b}, 32'h7);
        $display("test reset_and_refuse finished");
    endtask : t_reset_and_refuse

    task automatic t_pin_io;
        bus(1'b1, lpit_pkg::lpit_off_ctrl, 32'h1);
        bus(1'b1, lpit_pkg::lpit_off_dir, 32'h5);
        rd_chk(lpit_pkg::lpit_off_dir, 32'hd);
        bus(1'b1, lpit_pkg::lpit_off_out, 32'h1);
        repeat (2) @(posedge mclk);
        chk({29'h0, pin_oe_b}, 32'h2);
        chk({29'h0, pin_out[0], pin_out[2], programming_voltage_out}, 32'h4);
        bus(1'b1, lpit_pkg::lpit_off_toggle, 32'hd);
        repeat (2) @(posedge mclk);
        rd_chk(lpit_pkg::lpit_off_out, 32'hc);
        chk({29'h0, pin_out[0], pin_out[2], programming_voltage_out}, 32'h3);
        drive(3'h2, 3'h2, 4);
        rd_chk(lpit_pkg::lpit_off_in, 32'h6);
        drive(3'h0, 3'h0, 4);
        rd_chk(lpit_pkg::lpit_off_in, 32'h4);
        $display("test pin_io finished");
    endtask : t_pin_io

    task automatic t_rise_and_high;
        bus(1'b1, lpit_pkg::lpit_off_ctrl, 32'h2);
        bus(1'b1, lpit_pkg::lpit_off_trig, 32'h00b);
        bus(1'b1, lpit_pkg::lpit_off_acq, 32'h0);
        drive(3'h7, 3'h0, 4);
        chk({29'h0, pin_oe_b}, 32'h7);
        bus(1'b1, lpit_pkg::lpit_off_ctrl, 32'h6);
        drive(3'h7, 3'h1, 6);
        drive(3'h7, 3'h2, 6);
        rd_chk(lpit_pkg::lpit_off_status, 32'h2);
        drive(3'h7, 3'h3, 4);
        wait_done();
        bus(1'b1, lpit_pkg::lpit_off_capidx, 32'h0);
        rd_chk(lpit_pkg::lpit_off_capdata, 32'h3);
        bus(1'b1, lpit_pkg::lpit_off_capidx, 32'hf);
        rd_chk(lpit_pkg::lpit_off_capdata, 32'h3);
        $display("test rise_and_high finished");
    endtask : t_rise_and_high

    task automatic t_fall_and_low;
        bus(1'b1, lpit_pkg::lpit_off_ctrl, 32'ha);
        bus(1'b1, lpit_pkg::lpit_off_trig, 32'h110);
        drive(3'h7, 3'h1, 4);
        bus(1'b1, lpit_pkg::lpit_off_ctrl, 32'h6);
        drive(3'h7, 3'h5, 6);
        drive(3'h7, 3'h4, 6);
        rd_chk(lpit_pkg::lpit_off_status, 32'h2);
        drive(3'h7, 3'h5, 6);
        drive(3'h7, 3'h1, 6);
        wait_done();
        bus(1'b1, lpit_pkg::lpit_off_capidx, 32'h0);
        rd_chk(lpit_pkg::lpit_off_capdata, 32'h1);
        $display("test fall_and_low finished");
    endtask : t_fall_and_low

    task automatic t_delay;
        bus(1'b1, lpit_pkg::lpit_off_ctrl, 32'ha);
        bus(1'b1, lpit_pkg::lpit_off_trig, 32'h0);
        bus(1'b1, lpit_pkg::lpit_off_acq, 32'h0001_0009);
        bus(1'b1, lpit_pkg::lpit_off_ctrl, 32'h6);
        repeat (12) @(posedge mclk);
        // Fire at the first tick; one window of four ten-cycle ticks follows
        rd_chk(lpit_pkg::lpit_off_status, 32'h4);
        // Still waiting just before the fourth tick, recording just after it
        repeat (31) @(posedge mclk);
        rd_chk(lpit_pkg::lpit_off_status, 32'h4);
        rd_chk(lpit_pkg::lpit_off_status, 32'h8);
        wait_done();
        $display("test delay finished");
    endtask : t_delay

    initial begin
        bad_count = 0;
        n_compared = 0;
        cycles = 0;
        rst_b = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        drv_en = 3'h0;
        drv_val = 3'h0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (5) @(posedge mclk);
        t_reset_and_refuse();
        t_pin_io();
        t_rise_and_high();
        t_fall_and_low();
        t_delay();
        finish_test();
    end
endmodule : testbench
